// File: inc/arh_pkg.sv
/*
 types for the alarm reset and history log block.
 assumes arh_regs.svh is compiled with it.
*/
`include "arh_regs.svh"
package arh_pkg;
  typedef logic [`ARH_CODE_W-1:0] arh_code_t;   // alarm code
  typedef logic [`ARH_TIME_W-1:0] arh_time_t;   // 100 ms ticks
  typedef enum logic [1:0] {
    ARH_IDLE   = 2'b00,
    ARH_ACTIVE = 2'b01
  } arh_state_t;
endpackage

// File: inc/arh_regs.svh
/*
 constants for the alarm reset and history log block: widths, slot count,
 codes and timing counts. assumes a 200 MHz core clock.
*/
`ifndef ARH_REGS_SVH
`define ARH_REGS_SVH
`define ARH_CLK_MHZ        200
`define ARH_TICK_MS        100
`define ARH_TICK_CYC       (`ARH_CLK_MHZ * 1000 * `ARH_TICK_MS)
`define ARH_HOUR_S         3600
`define ARH_HOUR_TICKS     (`ARH_HOUR_S * 1000 / `ARH_TICK_MS)
`define ARH_SLOTS          10
`define ARH_IDX_W          4
`define ARH_CODE_W         12
`define ARH_TIME_W         32
`define ARH_PIN_W          3
`define ARH_PINS           8
`define ARH_PIN_DEFAULT    3'h0
`define ARH_NO_ALARM       12'h000
`endif

// File: src/arh_core.sv
/*
 alarm latch with pin selectable fault clear, and a ten slot alarm
 history with 100 ms operation time stamps. slot contents stand in
 flip-flops that are meant to map onto retained storage; reset_n is the
 power-on reset and does not touch them.
 assumes: inputs synchronous to core_clk; alarm_raise is a one-cycle pulse.
*/
`timescale 1ns/1ps
`include "arh_regs.svh"
module arh_core #(
  parameter int unsigned TICK_CYC   = `ARH_TICK_CYC,
  parameter int unsigned HOUR_TICKS = `ARH_HOUR_TICKS
) (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  // contact inputs and pin allocation
  input  wire logic [`ARH_PINS-1:0]   contact_in_n,
  input  wire logic [`ARH_PIN_W-1:0]  fault_clear_pin_select,
  // alarm sources
  input  wire logic                   alarm_raise,
  input  wire logic                   alarm_is_warning,
  input  wire arh_pkg::arh_code_t     alarm_code,
  // power status and history control
  input  wire logic                   power_on,
  input  wire logic                   hist_clear,
  input  wire logic                   param_write_prot,
  // outputs
  output logic                        fault_active_out,
  output arh_pkg::arh_code_t          active_code,
  output arh_pkg::arh_time_t          op_time,
  // history read port
  input  wire logic [`ARH_IDX_W-1:0]  hist_index,
  output arh_pkg::arh_code_t          hist_code,
  output arh_pkg::arh_time_t          hist_time
);
  // one clock and one reset for every check in this module
  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // 100 ms enable
  logic tick;
  arh_tick #(.DIV(TICK_CYC)) u_tick (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tick     (tick)
  );

  // selected fault clear contact, active low
  logic fault_clear_n;
  assign fault_clear_n = contact_in_n[fault_clear_pin_select];

  // alarm latch state
  arh_pkg::arh_state_t st_q;
  arh_pkg::arh_code_t  act_q;
  logic                alarm_ev;   // alarm-class event
  assign alarm_ev = alarm_raise && !alarm_is_warning;

  // operation time and since-last-store counters
  arh_pkg::arh_time_t op_q;
  arh_pkg::arh_time_t since_q;
  logic               time_run;
  assign time_run = tick && power_on;

  // history storage, index 0 holds slot 01
  arh_pkg::arh_code_t code_m [`ARH_SLOTS];
  arh_pkg::arh_time_t time_m [`ARH_SLOTS];
  logic               has_any_q;    // slot 01 holds a real entry

  // store decision
  logic same_code;
  logic recent;
  logic do_store;
  logic do_clear;
  assign same_code = has_any_q && (code_m[0] == alarm_code);
  assign recent    = since_q < 32'(HOUR_TICKS);
  assign do_store  = alarm_ev && !(same_code && recent);
  assign do_clear  = hist_clear && !param_write_prot;

  // alarm latch: set on alarm, cleared by fault clear; set wins
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q  <= arh_pkg::ARH_IDLE;
      act_q <= `ARH_NO_ALARM;
    end else begin
      case (st_q)
        arh_pkg::ARH_IDLE: begin
          if (alarm_ev) begin
            st_q  <= arh_pkg::ARH_ACTIVE;
            act_q <= alarm_code;
          end
        end
        arh_pkg::ARH_ACTIVE: begin
          if (alarm_ev) begin
            act_q <= alarm_code;
          end else if (!fault_clear_n) begin
            st_q  <= arh_pkg::ARH_IDLE;
            act_q <= `ARH_NO_ALARM;
          end
        end
        default: begin
          st_q <= arh_pkg::ARH_IDLE;
        end
      endcase
    end
  end
  assign fault_active_out = (st_q == arh_pkg::ARH_ACTIVE);
  assign active_code      = act_q;

  // 32-bit 100 ms counter: 2^32 ticks is about 13.6 years
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      op_q <= '0;
    end else if (time_run) begin
      op_q <= op_q + 32'h1;
    end
  end
  assign op_time = op_q;

  // ticks since the newest stored entry, saturating
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      since_q <= '0;
    end else if (do_store) begin
      since_q <= '0;
    end else if (time_run && since_q != 32'hffff_ffff) begin
      since_q <= since_q + 32'h1;
    end
  end

  // history shift: no reset, so alarm reset and power-on keep it
  always_ff @(posedge core_clk) begin
    if (do_clear) begin
      for (int i = 0; i < `ARH_SLOTS; i++) begin
        code_m[i] <= `ARH_NO_ALARM;
        time_m[i] <= '0;
      end
    end else if (do_store) begin
      for (int i = `ARH_SLOTS - 1; i > 0; i--) begin
        code_m[i] <= code_m[i-1];
        time_m[i] <= time_m[i-1];
      end
      code_m[0] <= alarm_code;
      time_m[0] <= op_q;
    end
  end

  // slot 01 valid flag, kept alongside the retained slots
  always_ff @(posedge core_clk) begin
    if (do_clear) begin
      has_any_q <= 1'b0;
    end else if (do_store) begin
      has_any_q <= 1'b1;
    end
  end

  // read port, index 1..10; others return the empty pattern
  logic idx_ok;
  logic [`ARH_IDX_W-1:0] idx0;
  assign idx_ok = (hist_index >= 4'h1) && (hist_index <= 4'ha);
  assign idx0   = hist_index - 4'h1;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_code <= `ARH_NO_ALARM;
      hist_time <= '0;
    end else begin
      hist_code <= idx_ok ? code_m[idx0] : `ARH_NO_ALARM;
      hist_time <= idx_ok ? time_m[idx0] : '0;
    end
  end

  // checks: alarm latch
  // selected contact low, no new alarm: latch must drop
  sequence s_clear_low;
    st_q == arh_pkg::ARH_ACTIVE && !alarm_ev && !fault_clear_n;
  endsequence
  // selected contact high, no new alarm: latch must hold
  sequence s_hold_high;
    st_q == arh_pkg::ARH_ACTIVE && !alarm_ev
      && contact_in_n[fault_clear_pin_select];
  endsequence
  alarm_clear_a: assert property (s_clear_low |=> !fault_active_out)
    else $error("fault clear did not clear alarm");
  pin_sel_a: assert property (s_hold_high |=> fault_active_out)
    else $error("unselected contact cleared alarm");
  alarm_set_a: assert property (alarm_ev |=> fault_active_out
    && active_code == $past(alarm_code))
    else $error("alarm not latched");
  // checks: history
  warn_skip_a: assert property (alarm_raise && alarm_is_warning
    && !do_clear |=> $stable(code_m[0]) && $stable(time_m[0])
    && $stable(code_m[9]))
    else $error("warning changed history");
  newest_first_a: assert property (do_store && !do_clear |=>
    code_m[0] == $past(alarm_code) && time_m[0] == $past(op_q)
    && code_m[1] == $past(code_m[0]))
    else $error("history did not shift");
  oldest_drop_a: assert property (do_store && !do_clear |=>
    code_m[9] == $past(code_m[8]))
    else $error("tenth slot wrong");
  repeat_skip_a: assert property (alarm_ev && same_code && recent
    && !do_clear |=> $stable(code_m[1]) && $stable(time_m[0]))
    else $error("repeat stored within hour");
  clear_prot_a: assert property (hist_clear && param_write_prot
    && !do_store |=> $stable(code_m[0]))
    else $error("protected clear erased history");
  clear_empty_a: assert property (do_clear |=>
    code_m[0] == `ARH_NO_ALARM && time_m[9] == '0)
    else $error("cleared slot not empty");
  read_empty_a: assert property (!idx_ok |=>
    hist_code == `ARH_NO_ALARM && hist_time == '0)
    else $error("out of range read not empty");
  // checks: operation time
  time_step_a: assert property (time_run |=>
    op_q == $past(op_q) + 32'h1)
    else $error("operation time did not step");
  time_hold_a: assert property (!time_run |=> $stable(op_q))
    else $error("operation time moved while idle");
endmodule // arh_core

// File: src/arh_tick.sv
/*
 one-cycle enable divider: pulses once every DIV cycles.
 assumes a single free running clock.
*/
`timescale 1ns/1ps
module arh_tick #(
  parameter int unsigned DIV = 20000000
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // enable out
  output logic      tick
);
  logic [31:0] cnt_q;  // cycle counter
  logic        wrap;   // end of period
  assign wrap = (cnt_q == 32'(DIV - 1));
  // free running count, wraps at DIV
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= wrap ? 32'h0 : cnt_q + 32'h1;
    end
  end
  assign tick = wrap;
endmodule // arh_tick

// File: testbench/alarm_reset_and_history_log_tb.sv
/*
 self-checking bench for the alarm latch and history log.
 assumes arh_core with 4-cycle ticks and a 5-tick repeat window.
*/
`timescale 1ns/1ps
`include "arh_regs.svh"
module alarm_reset_and_history_log_tb;
  logic core_clk = 1'b0, reset_n = 1'b0, press = 1'b0;
  logic alarm_raise = 1'b0, alarm_is_warning = 1'b0, power_on = 1'b1;
  logic hist_clear = 1'b0, param_write_prot = 1'b0, fault_active_out;
  logic [2:0] pin_sel = 3'h5, host_pin = 3'h0;
  logic [3:0] hist_index = 4'h1;
  logic [7:0] contact_in_n;
  arh_pkg::arh_code_t alarm_code = 12'h000, active_code, hist_code;
  arh_pkg::arh_time_t op_time, hist_time, prev;
  int mismatches = 0, checked = 0, cycles = 0;
  // clock and watchdog
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      wrap_up();
    end
  end
  arh_host host (.press(press), .pin(host_pin),
    .contact_in_n(contact_in_n));
  arh_core #(.TICK_CYC(4), .HOUR_TICKS(5)) dut (.core_clk(core_clk),
    .reset_n(reset_n), .contact_in_n(contact_in_n),
    .fault_clear_pin_select(pin_sel), .alarm_raise(alarm_raise),
    .alarm_is_warning(alarm_is_warning), .alarm_code(alarm_code),
    .power_on(power_on), .hist_clear(hist_clear),
    .param_write_prot(param_write_prot),
    .fault_active_out(fault_active_out), .active_code(active_code),
    .op_time(op_time), .hist_index(hist_index), .hist_code(hist_code),
    .hist_time(hist_time));
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic raise(input logic [11:0] c, input logic w);
    alarm_raise = 1'b1;
    alarm_code = c;
    alarm_is_warning = w;
    cyc(1);
    alarm_raise = 1'b0;
  endtask
  task automatic rd(input logic [3:0] i);
    hist_index = i;
    cyc(1);
  endtask
  // press the given contact for two cycles
  task automatic push(input logic [2:0] p);
    host_pin = p;
    press = 1'b1;
    cyc(2);
    press = 1'b0;
  endtask
  task automatic t_clear();
    hist_clear = 1'b1;
    cyc(1);
    hist_clear = 1'b0;
    for (int i = 1; i <= 11; i++) begin
      rd(4'(i));
      chk("empty code", 32'h0, 32'(hist_code));
      chk("empty time", 32'h0, hist_time);
    end
  endtask
  // twelve alarms two ticks apart: oldest two fall out
  task automatic t_fill();
    for (int k = 0; k < 12; k++) begin
      raise(12'h100 + 12'(k), 1'b0);
      cyc(7);
    end
    chk("alarm out", 32'h1, 32'(fault_active_out));
    chk("active code", 32'h10b, 32'(active_code));
    for (int i = 1; i <= 10; i++) begin
      rd(4'(i));
      chk("slot code", 32'h10b - i + 1, 32'(hist_code));
      if (i > 1) chk("stamp step", 32'h2, prev - hist_time);
      prev = hist_time;
    end
  endtask
  task automatic t_pin();
    push(3'h2);
    chk("wrong pin", 32'h1, 32'(fault_active_out));
    push(3'h0);
    chk("default pin", 32'h1, 32'(fault_active_out));
    push(3'h5);
    chk("cleared", 32'h0, 32'(fault_active_out));
    chk("code cleared", 32'h0, 32'(active_code));
    rd(4'h1);
    chk("kept on reset", 32'h10b, 32'(hist_code));
    raise(12'h7aa, 1'b1);
    cyc(1);
    chk("warn out", 32'h0, 32'(fault_active_out));
    rd(4'h1);
    chk("warn log", 32'h10b, 32'(hist_code));
  endtask
  task automatic t_repeat();
    raise(12'h222, 1'b0);
    cyc(7);
    raise(12'h222, 1'b0);
    rd(4'h2);
    chk("repeat skip", 32'h10b, 32'(hist_code));
    cyc(22);
    raise(12'h222, 1'b0);
    rd(4'h2);
    chk("repeat store", 32'h222, 32'(hist_code));
    push(3'h5);
  endtask
  task automatic t_prot();
    param_write_prot = 1'b1;
    hist_clear = 1'b1;
    cyc(1);
    hist_clear = 1'b0;
    rd(4'h1);
    chk("prot clear", 32'h222, 32'(hist_code));
    reset_n = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    rd(4'h1);
    chk("power loss", 32'h222, 32'(hist_code));
    chk("time reset", 32'h0, op_time);
    param_write_prot = 1'b0;
    t_clear();
  endtask
  // operation time stands still without power, two ticks per 8 cycles
  task automatic t_power();
    power_on = 1'b0;
    cyc(1);
    prev = op_time;
    cyc(12);
    chk("time held", 32'h0, op_time - prev);
    power_on = 1'b1;
    prev = op_time;
    cyc(8);
    chk("time run", 32'h2, op_time - prev);
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(10);
    reset_n = 1'b1;
    chk("time width", 32'h1, 32'($bits(op_time) >= 32));
    t_clear();
    t_fill();
    t_pin();
    t_repeat();
    t_prot();
    t_power();
    wrap_up();
  end
endmodule // alarm_reset_and_history_log_tb

// File: testbench/arh_host.sv
/*
 host controller model: drives the contact inputs of the drive.
 assumes contacts idle high through pull-ups, one contact pressed at once.
*/
`timescale 1ns/1ps
`include "arh_regs.svh"
module arh_host (
  // request from the bench
  input  wire logic                  press,
  input  wire logic [`ARH_PIN_W-1:0] pin,
  // contact lines to the drive
  output logic [`ARH_PINS-1:0]       contact_in_n
);
  // pressed contact pulls its line low, the rest idle high
  assign contact_in_n = press ? ~(8'h01 << pin) : 8'hff;
endmodule // arh_host
